/* hdl/iel_entry.v */
// iel_entry.v: interrupt entry logic of a two-cycle 8-bit core
// assumes: request and controls from logic on the same clock
//
// Operation
// - accepted interrupt calls vector, pushing return address
// - vector is parameter, default 3FF hex
// - each instruction takes exactly two cycles
// - request sampled once per instruction only
// - entry within one or two cycles
// - take only if high, enabled, awake, idle
// - sleep ignores the request entirely
// - cancel next, save flags, bank, load vector
// - cancelled address becomes the return point
// - requests are not latched internally
// - acknowledge marks start of service routine
// - only one interrupt serviced at once
`timescale 1ns/1ns
`include "iel_map.vh"
module iel_entry #(
   parameter [`IEL_ADDR_W-1:0] VECTOR = `IEL_VECTOR_DEF
) (
   input  wire                   CLK,
   input  wire                   RST_N,
   input  wire                   INT_REQ,
   input  wire                   SLEEP,
   input  wire                   INT_ENABLE_SET,
   input  wire                   INT_ENABLE_CLR,
   input  wire                   FLAG_ZERO,
   input  wire                   FLAG_CARRY,
   input  wire                   BANK_SEL,
   input  wire [`IEL_ADDR_W-1:0] NEXT_ADDR,
   input  wire [17:0]            INSTRUCTION,
   output wire                   INT_ACK,
   output wire                   CANCEL_NEXT,
   output wire                   PC_LOAD,
   output wire [`IEL_ADDR_W-1:0] PC_VALUE,
   output wire                   INT_ENABLED,
   output wire                   IN_SERVICE,
   output wire                   SAVED_ZERO,
   output wire                   SAVED_CARRY,
   output wire                   SAVED_BANK,
   output wire                   RETURN_SEEN,
   output wire                   STACK_OVERFLOW
);
   reg                   ack_ff;
   reg                   ie_ff;
   reg                   busy_ff;
   reg                   sz_ff;
   reg                   sc_ff;
   reg                   sb_ff;
   reg                   load_ff;
   reg [`IEL_ADDR_W-1:0] pcv_ff;
   reg                   ret_ff;
   wire                  exec_en;
   wire                  take;
   wire                  is_return;
   wire [`IEL_ADDR_W-1:0] top_addr;

   function is_reti;
      input [17:0] ins;
      begin
         is_reti = (ins[`IEL_OPC_HI:`IEL_OPC_LO] == `IEL_RETI_OPC);
      end
   endfunction

   // instruction pacing, frozen in sleep
   iel_phase u_phase (
      .clk     (CLK),
      .rst_n   (RST_N),
      .hold    (SLEEP),
      .exec_en (exec_en)
   );

   // return point store
   iel_stack u_stack (
      .clk       (CLK),
      .rst_n     (RST_N),
      .push      (take),
      .pop       (is_return),
      .push_addr (NEXT_ADDR),
      .top_addr  (top_addr),
      .overflow  (STACK_OVERFLOW)
   );

   // request read straight from the pin at each instruction boundary
   assign take = exec_en & INT_REQ & ie_ff & ~busy_ff & ~SLEEP;
   assign is_return = exec_en & busy_ff & is_reti(INSTRUCTION);

   assign INT_ACK        = ack_ff;
   assign CANCEL_NEXT    = load_ff;
   assign PC_LOAD        = load_ff;
   assign PC_VALUE       = pcv_ff;
   assign INT_ENABLED    = ie_ff;
   assign IN_SERVICE     = busy_ff;
   assign SAVED_ZERO     = sz_ff;
   assign SAVED_CARRY    = sc_ff;
   assign SAVED_BANK     = sb_ff;
   assign RETURN_SEEN    = ret_ff;

   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ack_ff  <= 1'b0;
         ie_ff   <= 1'b0;
         busy_ff <= 1'b0;
         sz_ff   <= 1'b0;
         sc_ff   <= 1'b0;
         sb_ff   <= 1'b0;
         load_ff <= 1'b0;
         pcv_ff  <= {`IEL_ADDR_W{1'b0}};
         ret_ff  <= 1'b0;
      end else begin
         ack_ff  <= take;
         load_ff <= take | is_return;
         ret_ff  <= is_return;
         if (take) begin
            pcv_ff  <= VECTOR;
            sz_ff   <= FLAG_ZERO;
            sc_ff   <= FLAG_CARRY;
            sb_ff   <= BANK_SEL;
            busy_ff <= 1'b1;
            ie_ff   <= 1'b0;
         end else begin
            if (is_return) begin
               pcv_ff  <= top_addr;
               busy_ff <= 1'b0;
            end
            if (INT_ENABLE_SET) begin
               ie_ff <= 1'b1;
            end else if (INT_ENABLE_CLR) begin
               ie_ff <= 1'b0;
            end
         end
      end
   end
endmodule

/* shared/iel_map.vh */
// iel_map.vh: constants of the interrupt entry logic
// assumes: included by the design files under hdl/
`ifndef IEL_MAP_VH
`define IEL_MAP_VH
`define IEL_VECTOR_DEF     12'h3FF
`define IEL_ADDR_W         12
`define IEL_STACK_DEPTH    30
`define IEL_RETI_OPC       6'h29
`define IEL_OPC_HI         17
`define IEL_OPC_LO         12
`define IEL_INSTR_CYC      2
`endif

/* hdl/iel_phase.v */
// iel_phase.v: instruction phase divider, one enable pulse per instruction
// assumes: single clock domain, stall input holds the phase (sleep)
`timescale 1ns/1ns
`include "iel_map.vh"
module iel_phase (
   input  wire clk,
   input  wire rst_n,
   input  wire hold,
   output wire exec_en
);
   localparam integer LAST     = `IEL_INSTR_CYC - 1;
   localparam [1:0]   LAST_CNT = LAST[1:0];
   reg [1:0]  cnt_ff;
   wire [1:0] nxt_cnt;
   // one instruction every two cycles
   assign nxt_cnt = (cnt_ff == LAST_CNT) ? 2'h0 : cnt_ff + 2'h1;
   assign exec_en = ~hold & (cnt_ff == LAST_CNT);
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 2'h0;
      end else if (!hold) begin
         cnt_ff <= nxt_cnt;
      end
   end
endmodule

/* hdl/iel_stack.v */
// iel_stack.v: call stack holding return addresses
// assumes: push and pop never in the same cycle
`timescale 1ns/1ns
`include "iel_map.vh"
module iel_stack #(
   parameter AW    = `IEL_ADDR_W,
   parameter DEPTH = `IEL_STACK_DEPTH
) (
   input  wire          clk,
   input  wire          rst_n,
   input  wire          push,
   input  wire          pop,
   input  wire [AW-1:0] push_addr,
   output wire [AW-1:0] top_addr,
   output wire          overflow
);
   reg [AW-1:0] mem [0:DEPTH-1];
   reg [4:0]    ptr_ff;
   reg          ovf_ff;
   assign top_addr = (ptr_ff == 5'h00) ? {AW{1'b0}} : mem[ptr_ff - 5'h01];
   assign overflow = ovf_ff;
   always @(posedge clk) begin
      if (push && ptr_ff < DEPTH[4:0]) begin
         mem[ptr_ff] <= push_addr;
      end
   end
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ptr_ff <= 5'h00;
         ovf_ff <= 1'b0;
      end else if (push) begin
         if (ptr_ff < DEPTH[4:0]) begin
            ptr_ff <= ptr_ff + 5'h01;
         end else begin
            ovf_ff <= 1'b1;
         end
      end else if (pop && ptr_ff != 5'h00) begin
         ptr_ff <= ptr_ff - 5'h01;
      end
   end
endmodule

/* tb/iel_req_model.sv */
// iel_req_model.sv: closed-loop requester on the far side
// assumes: same clock as the entry logic, evt from the bench
`timescale 1ns/1ns
module iel_req_model (
   input  wire clk,
   input  wire rst_n,
   input  wire evt,
   input  wire ack,
   output reg  req
);
   // hold until acknowledged, ack wins over a new event
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         req <= 1'b0;
      else if (ack)
         req <= 1'b0;
      else if (evt)
         req <= 1'b1;
   end
endmodule

/* tb/iel_entry_asserts.sv */
// iel_entry_asserts.sv: port checker of the interrupt entry logic
// assumes: bound to iel_entry, one clock domain
`timescale 1ns/1ns
`include "iel_map.vh"
module iel_entry_asserts #(
   parameter [`IEL_ADDR_W-1:0] VECTOR = `IEL_VECTOR_DEF
) (
   input wire                   CLK,
   input wire                   RST_N,
   input wire                   INT_REQ,
   input wire                   SLEEP,
   input wire                   INT_ACK,
   input wire                   CANCEL_NEXT,
   input wire                   PC_LOAD,
   input wire [`IEL_ADDR_W-1:0] PC_VALUE,
   input wire                   INT_ENABLED,
   input wire                   IN_SERVICE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   sequence s_arm;
      $rose(INT_REQ) && INT_ENABLED && !IN_SERVICE && !SLEEP;
   endsequence
   property p_resp; s_arm |-> ##[1:2] INT_ACK; endproperty
   a_resp: assert property (p_resp) else $error("late ack");
   property p_pulse; INT_ACK |=> !INT_ACK; endproperty
   a_pulse: assert property (p_pulse) else $error("long ack");
   property p_load; INT_ACK |-> PC_LOAD && CANCEL_NEXT; endproperty
   a_load: assert property (p_load) else $error("no load");
   property p_vec; INT_ACK |-> PC_VALUE == VECTOR; endproperty
   a_vec: assert property (p_vec) else $error("bad vector");
   property p_take;
      INT_ACK |-> $past(INT_REQ && INT_ENABLED && !IN_SERVICE);
   endproperty
   a_take: assert property (p_take) else $error("bad take");
   property p_sleep; $past(SLEEP) |-> !INT_ACK; endproperty
   a_sleep: assert property (p_sleep) else $error("ack asleep");
   property p_one; $past(IN_SERVICE) |-> !INT_ACK; endproperty
   a_one: assert property (p_one) else $error("nested ack");
   property p_clr; INT_ACK |-> !INT_ENABLED && IN_SERVICE; endproperty
   a_clr: assert property (p_clr) else $error("enable kept");
endmodule
bind iel_entry iel_entry_asserts #(.VECTOR(VECTOR)) u_chk (.*);

/* tb/iel_entry_tb.sv */
// iel_entry_tb.sv: directed bench of the interrupt entry logic
// assumes: closed-loop requester model, inputs driven on falling edge
`timescale 1ns/1ns
module iel_entry_tb;
   reg         clk = 0, rst_n = 0, evt = 0, slp = 0, es = 0, ec = 0;
   reg  [17:0] ins = 18'h00000;
   reg  [2:0]  flg = 3'b101;
   wire        req, ack, ies, isv, sz, sc, sb, rs, ovf;
   wire [11:0] pcv;
   integer     fail_count = 0, checks_done = 0, n_ack = 0, n_ret = 0;
   iel_req_model u_req (.clk(clk), .rst_n(rst_n), .evt(evt), .ack(ack),
      .req(req));
   iel_entry u_dut (.CLK(clk), .RST_N(rst_n), .INT_REQ(req), .SLEEP(slp),
      .INT_ENABLE_SET(es), .INT_ENABLE_CLR(ec), .FLAG_ZERO(flg[2]),
      .FLAG_CARRY(flg[1]), .BANK_SEL(flg[0]), .NEXT_ADDR(12'h123),
      .INSTRUCTION(ins), .INT_ACK(ack), .CANCEL_NEXT(), .PC_LOAD(),
      .PC_VALUE(pcv), .INT_ENABLED(ies), .IN_SERVICE(isv),
      .SAVED_ZERO(sz), .SAVED_CARRY(sc), .SAVED_BANK(sb),
      .RETURN_SEEN(rs), .STACK_OVERFLOW(ovf));
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      n_ack = n_ack + ack;
      n_ret = n_ret + rs;
   end
   task chk(input [11:0] g, input [11:0] e);
      checks_done = checks_done + 1;
      if (g !== e) begin
         fail_count = fail_count + 1;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task step(input integer n);
      repeat (n) @(negedge clk);
   endtask
   // one-cycle pulse on {evt, es, ec} chosen by mask
   task pls(input [2:0] m);
      {evt, es, ec} = m;
      step(1);
      {evt, es, ec} = 3'b000;
   endtask
   task wt(input integer e);
      repeat (30) if (n_ack < e) step(1);
      step(1);
   endtask
   task ret;
      ins = 18'h29000;
      step(2);
      ins = 18'h00000;
      step(3);
   endtask
   task end_sim;
      $display("checks %0d fails %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // watchdog: whole sequence needs well under 200 cycles
   initial begin
      #20000 fail_count = fail_count + 1;
      end_sim;
   end
   initial begin
      step(6);
      rst_n = 1;
      pls(3'b010);
      chk(ies, 1);
      pls(3'b100);
      wt(1);
      chk(pcv, 12'h3FF);
      chk({sz, sc, sb}, 3'b101);
      chk({ies, isv}, 2'b01);
      flg = 3'b010;
      pls(3'b100);
      step(8);
      chk(n_ack, 1);
      ret;
      chk(pcv, 12'h123);
      chk(n_ret, 1);
      step(8);
      chk(n_ack, 1);
      slp = 1;
      pls(3'b010);
      step(8);
      chk(n_ack, 1);
      slp = 0;
      wt(2);
      chk(n_ack, 2);
      chk({sz, sc, sb}, 3'b010);
      pls(3'b001);
      ret;
      chk(isv, 0);
      chk(ovf, 0);
      end_sim;
   end
endmodule
